// >>> core/fld_ctrl.sv
// Functional notes
// - Ready output high once output voltage is within 100mV of ceiling.
// - Torch operation uses a fixed 4.50V ceiling for ready.
// - Flash operation takes ceiling from the level register's top three bits.
// - Power-down input low means shutdown with all LED sources off.
// - Power-down low with retention clear zeroes every register bit.
// - Power-down low with retention set keeps every register bit unchanged.
// - Flash mode plus strobe trigger lights LEDs for one timeout period.
// - Timeout length comes from the two lowest control bits.
// - LED sources follow strobe register in flash, steady register in torch.
// - Shorted LED detected near the ceiling switches LED current off.
// - Serial clock and data spikes shorter than 50ns are ignored.
// - Serial interface is ready within 1us after undervoltage clears.
// - Controller can read registers back as well as write them.
// - Ceiling code 000 is 4.55V, plus 0.15V per step, to 5.60V.
// - Timeout codes give 0.11s, 0.22s, 0.53s and 1.10s.
// - Mode 01 and 10 are torch, 11 is flash; gain bits pass out.
module fld_ctrl #(
  parameter int unsigned TOUT0_CYC = fld_pkg::TOUT0_US * fld_pkg::CLK_MHZ,
  parameter int unsigned TOUT1_CYC = fld_pkg::TOUT1_US * fld_pkg::CLK_MHZ,
  parameter int unsigned TOUT2_CYC = fld_pkg::TOUT2_US * fld_pkg::CLK_MHZ,
  parameter int unsigned TOUT3_CYC = fld_pkg::TOUT3_US * fld_pkg::CLK_MHZ
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              pwr_down_n_i,
  input  wire logic              strobe_trig_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic              uvlo_i,
  input  wire logic              temp_fault_i,
  input  wire logic [2:0]        led_short_i,
  input  wire logic [12:0]       vout_mv_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   ready_o,
  output logic                   shutdown_o,
  output logic                   strobe_active_o,
  output logic [1:0]             pump_gain_o,
  output fld_pkg::fld_led_t      led_o
);
  import fld_pkg::*;

  logic [8:0]        meta;
  logic [8:0]        sync;
  logic              pwr_n_s, trig_s, scl_s, sda_s, uvlo_s, temp_s;
  logic [2:0]        short_s;
  logic [1:0]        raw, filt;
  logic              scl_f, sda_f, scl_d, sda_d, trig_d;
  logic              scl_rise, scl_fall, start, stop;
  fld_i2c_st_t       st, next_st;
  logic [3:0]        bitcnt, next_bit;
  logic [7:0]        sh, next_sh, rd_byte;
  logic              is_addr, next_addr, rw, next_rw, next_oe;
  logic [1:0]        ptr, next_ptr;
  fld_regs_t         regs, next_regs;
  logic              flash_mode, torch_mode, strobe_go;
  logic              active, next_active;
  logic [TMR_W-1:0]  cnt, next_cnt, sel_cyc;
  logic [12:0]       ceil_mv, thresh_mv;
  logic              led_on, next_ready;
  fld_led_t          next_led;
  fld_cur_t          src;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Two-flop synchronisers for every single-bit pin and analog flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= SYNC_RST;
      sync <= SYNC_RST;
    end else begin
      meta <= {pwr_down_n_i, strobe_trig_i, scl_i, sda_i, uvlo_i,
               temp_fault_i, led_short_i};
      sync <= meta;
    end
  end

  assign {pwr_n_s, trig_s, scl_s, sda_s, uvlo_s, temp_s, short_s} = sync;
  assign raw   = {scl_s, sda_s};
  assign scl_f = filt[1];
  assign sda_f = filt[0];

  // Spike filter: a level must hold FILT_CYC samples to be accepted
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [1:0] fcnt, next_fcnt;
    logic       f, next_f;
    always_comb begin
      next_f    = f;
      next_fcnt = 2'h0;
      if (raw[g] != f) begin
        if (fcnt == 2'(FILT_CYC - 1)) next_f = raw[g];
        else next_fcnt = fcnt + 2'h1;
      end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        fcnt <= 2'h0;
        f    <= 1'b1;
      end else begin
        fcnt <= next_fcnt;
        f    <= next_f;
      end
    end
    assign filt[g] = f;
  end

  // Previous filtered bus levels and synchronised trigger level for edge and condition detection
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
      trig_d <= 1'b0;
    end else begin
      scl_d  <= scl_f;
      sda_d  <= sda_f;
      trig_d <= trig_s;
    end
  end

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start    = scl_f & scl_d & sda_d & ~sda_f;
  assign stop     = scl_f & scl_d & ~sda_d & sda_f;

  // Read-back mux; status bits reflect live state
  always_comb begin
    unique case (ptr)
      REG_CTRL:   rd_byte = regs.ctrl;
      REG_LEVEL:  rd_byte = {regs.vlim, ready_o, uvlo_s, temp_s, 2'h0};
      REG_STROBE: rd_byte = regs.strobe;
      REG_STEADY: rd_byte = regs.steady;
    endcase
  end

  // Bus slave and register file next state
  always_comb begin
    next_st   = st;
    next_bit  = bitcnt;
    next_sh   = sh;
    next_addr = is_addr;
    next_rw   = rw;
    next_ptr  = ptr;
    next_regs = regs;
    unique case (st)
      ST_IDLE: ;
      ST_RX: begin
        if (scl_rise) begin
          next_sh  = {sh[6:0], sda_f};
          next_bit = bitcnt + 4'h1;
        end else if (scl_fall && bitcnt == 4'h8) begin
          next_bit = 4'h0;
          if (is_addr) begin
            next_rw = sh[0];
            next_st = (sh[7:1] == DEV_ADDR) ? ST_ACK : ST_IDLE;
          end else begin
            next_st  = ST_ACK;
            next_ptr = ptr + 2'h1;
            unique case (ptr)
              REG_CTRL:   next_regs.ctrl   = fld_ctrl_t'(sh);
              REG_LEVEL:  next_regs.vlim   = sh[7:5];
              REG_STROBE: next_regs.strobe = fld_cur_t'(sh);
              REG_STEADY: next_regs.steady = fld_cur_t'(sh);
            endcase
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          next_addr = 1'b0;
          if (is_addr && rw) begin
            next_st  = ST_TX;
            next_sh  = rd_byte;
            next_ptr = ptr + 2'h1;
          end else begin
            next_st = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          next_sh  = {sh[6:0], 1'b0};
          next_bit = bitcnt + 4'h1;
          if (bitcnt == 4'h7) begin
            next_st  = ST_TACK;
            next_bit = 4'h0;
          end
        end
      end
      ST_TACK: begin
        if (scl_rise && sda_f) begin
          next_st = ST_IDLE;
        end else if (scl_fall) begin
          next_st  = ST_TX;
          next_sh  = rd_byte;
          next_ptr = ptr + 2'h1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    if (start) begin
      next_st   = ST_RX;
      next_bit  = 4'h0;
      next_addr = 1'b1;
      next_ptr  = REG_CTRL;
    end
    // Held idle in lockout so the slave is ready as soon as it clears
    if (stop || uvlo_s) next_st = ST_IDLE;
    // Shutdown freezes or wipes the registers, bus writes lose
    if (!pwr_n_s) begin
      next_regs = regs.ctrl.keep ? regs : REGS_RST;
    end
    next_oe = (next_st == ST_ACK) || (next_st == ST_TX && !next_sh[7]);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st       <= ST_IDLE;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      is_addr  <= 1'b0;
      rw       <= 1'b0;
      ptr      <= REG_CTRL;
      regs     <= REGS_RST;
      sda_oe_o <= 1'b0;
    end else begin
      st       <= next_st;
      bitcnt   <= next_bit;
      sh       <= next_sh;
      is_addr  <= next_addr;
      rw       <= next_rw;
      ptr      <= next_ptr;
      regs     <= next_regs;
      sda_oe_o <= next_oe;
    end
  end

  // Mode decode and timeout selection
  assign flash_mode = (regs.ctrl.mode == MODE_FLASH);
  assign torch_mode = (regs.ctrl.mode == MODE_TORCH_A) ||
                      (regs.ctrl.mode == MODE_TORCH_B);
  assign strobe_go  = flash_mode && pwr_n_s && trig_s && !trig_d &&
                      !active;

  always_comb begin
    unique case (regs.ctrl.tout)
      2'h0: sel_cyc = TMR_W'(TOUT0_CYC);
      2'h1: sel_cyc = TMR_W'(TOUT1_CYC);
      2'h2: sel_cyc = TMR_W'(TOUT2_CYC);
      2'h3: sel_cyc = TMR_W'(TOUT3_CYC);
    endcase
  end

  // Strobe timer; leaving flash mode or shutdown aborts it
  always_comb begin
    next_active = active;
    next_cnt    = cnt;
    if (!flash_mode || !pwr_n_s) begin
      next_active = 1'b0;
      next_cnt    = '0;
    end else if (strobe_go) begin
      next_active = 1'b1;
      next_cnt    = sel_cyc;
    end else if (active) begin
      next_cnt = cnt - TMR_W'(1);
      if (cnt == TMR_W'(1)) next_active = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      active <= 1'b0;
      cnt    <= '0;
    end else begin
      active <= next_active;
      cnt    <= next_cnt;
    end
  end

  // Ready threshold and LED drive selection
  always_comb begin
    ceil_mv    = flash_mode ? FLASH_BASE_MV + 13'(regs.vlim) * FLASH_STEP_MV
                            : TORCH_CEIL_MV;
    thresh_mv  = ceil_mv - READY_MARGIN_MV;
    next_ready = pwr_n_s && (vout_mv_i >= thresh_mv);
    src        = flash_mode ? regs.strobe : regs.steady;
    // Any short cuts every channel: channels may be tied together
    led_on     = pwr_n_s && (short_s == 3'h0) &&
                 (torch_mode || (flash_mode && active));
    next_led.en    = led_on ? {src.en[0], src.en[1], src.en[2]} : 3'h0;
    next_led.level = !led_on   ? 4'h0 :
                     flash_mode ? {1'b0, src.lvl[4:2]} : src.lvl[4:1];
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o         <= 1'b0;
      led_o           <= '0;
      shutdown_o      <= 1'b1;
      strobe_active_o <= 1'b0;
      pump_gain_o     <= 2'h0;
      sda_o           <= 1'b0;
    end else begin
      ready_o         <= next_ready;
      led_o           <= next_led;
      shutdown_o      <= !pwr_n_s;
      strobe_active_o <= next_active;
      pump_gain_o     <= regs.ctrl.gain;
      sda_o           <= 1'b0;
    end
  end

  sequence s_fire;
    strobe_go ##1 active;
  endsequence

  sequence s_last;
    active && flash_mode && pwr_n_s && cnt == TMR_W'(1);
  endsequence

  a_ready_torch: assert property ((torch_mode && pwr_n_s &&
      vout_mv_i >= TORCH_CEIL_MV - READY_MARGIN_MV) |=> ready_o)
    else $error("ready low above torch threshold");
  a_ready_flash: assert property ((flash_mode && vout_mv_i <
      FLASH_BASE_MV + 13'(regs.vlim) * FLASH_STEP_MV - READY_MARGIN_MV)
      |=> !ready_o)
    else $error("ready high below flash threshold");
  a_ready_off: assert property (!pwr_n_s |=> !ready_o)
    else $error("ready high in shutdown");
  a_shdn_dark: assert property (!pwr_n_s |=>
      led_o.en == 3'h0 && shutdown_o)
    else $error("LED enabled in shutdown");
  a_shdn_clear: assert property ((!pwr_n_s && !regs.ctrl.keep) |=>
      regs == REGS_RST)
    else $error("registers not cleared in shutdown");
  a_shdn_keep: assert property ((!pwr_n_s && regs.ctrl.keep) |=>
      regs == $past(regs))
    else $error("registers changed in retained shutdown");
  a_strobe_load: assert property (s_fire |-> cnt == $past(sel_cyc))
    else $error("timeout not loaded from selected code");
  a_strobe_end: assert property (s_last |=> !active && cnt == TMR_W'(0))
    else $error("strobe outlived its timeout");
  a_no_restart: assert property ((active && flash_mode && pwr_n_s &&
      cnt != TMR_W'(1)) |=> active && cnt == $past(cnt) - TMR_W'(1))
    else $error("strobe timer restarted or stalled");
  a_torch_src: assert property ((torch_mode && pwr_n_s &&
      short_s == 3'h0) |=> led_o.level == $past(regs.steady.lvl[4:1]))
    else $error("torch level not from steady register");
  a_short_off: assert property (short_s != 3'h0 |=> led_o.en == 3'h0)
    else $error("LED left on during short");
  a_spike_filt: assert property ($changed(scl_f) |->
      $past(scl_s) == scl_f && $past(scl_s, 2) == scl_f)
    else $error("serial clock spike passed filter");
  a_uvlo_idle: assert property (uvlo_s |=> st == ST_IDLE && !sda_oe_o)
    else $error("slave active during lockout");
  a_read_load: assert property ((st == ST_ACK && is_addr && rw &&
      scl_fall && !start && !stop && !uvlo_s) |=>
      st == ST_TX && sh == $past(rd_byte))
    else $error("read byte not loaded after address");

endmodule // fld_ctrl

// >>> shared/fld_pkg.sv
package fld_pkg;

  // Clock and time base
  localparam int CLK_MHZ  = 20;
  localparam int CLK_NS   = 50;

  // Spike suppression: a change must outlive the spike width
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = SPIKE_NS / CLK_NS + 1;

  // Strobe timeout lengths in microseconds, one per timeout code
  localparam int TOUT0_US = 110000;
  localparam int TOUT1_US = 220000;
  localparam int TOUT2_US = 530000;
  localparam int TOUT3_US = 1100000;
  localparam int TMR_W    = 25;

  // Output voltage ceilings and ready margin, millivolts
  localparam logic [12:0] TORCH_CEIL_MV   = 13'h1194;
  localparam logic [12:0] FLASH_BASE_MV   = 13'h11C6;
  localparam logic [12:0] FLASH_STEP_MV   = 13'h0096;
  localparam logic [12:0] READY_MARGIN_MV = 13'h0064;

  // Operating mode codes
  localparam logic [1:0] MODE_TORCH_A = 2'h1;
  localparam logic [1:0] MODE_TORCH_B = 2'h2;
  localparam logic [1:0] MODE_FLASH   = 2'h3;

  // Serial bus slave address and register pointer values
  localparam logic [6:0] DEV_ADDR    = 7'h28;
  localparam logic [1:0] REG_CTRL    = 2'h0;
  localparam logic [1:0] REG_LEVEL   = 2'h1;
  localparam logic [1:0] REG_STROBE  = 2'h2;
  localparam logic [1:0] REG_STEADY  = 2'h3;

  // Synchroniser reset: bus lines idle high, all else low
  localparam logic [8:0] SYNC_RST = 9'h060;

  typedef struct packed {
    logic [1:0] mode;
    logic       keep;
    logic [1:0] gain;
    logic       spare;
    logic [1:0] tout;
  } fld_ctrl_t;

  typedef struct packed {
    logic [2:0] en;
    logic [4:0] lvl;
  } fld_cur_t;

  typedef struct packed {
    fld_ctrl_t  ctrl;
    logic [2:0] vlim;
    fld_cur_t   strobe;
    fld_cur_t   steady;
  } fld_regs_t;

  localparam fld_regs_t REGS_RST = '0;

  typedef struct packed {
    logic [2:0] en;
    logic [3:0] level;
  } fld_led_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_TACK = 3'h6
  } fld_i2c_st_t;

endpackage

// >>> testbench/fld_i2c_host.sv
// Serial bus controller model; the data line is released high via pull-up
module fld_i2c_host (
  input  wire logic mclk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow bits keep every phase far above the input filter latency
  localparam int HALF = 10;
  logic spike_en;

  // Bus idles released
  initial begin
    scl_o    = 1'b1;
    sda_o    = 1'b1;
    spike_en = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // One bit; data held 2 cycles past the clock fall for hold time
  task automatic bit_xfer(input logic b, output logic r);
    sda_o <= b;
    wait_cyc(HALF / 2);
    // Short clock pulse that the device has to swallow
    if (spike_en) begin
      scl_o <= 1'b1;
      wait_cyc(1);
      scl_o <= 1'b0;
    end
    wait_cyc(HALF / 2);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    r = sda_line_i;
    scl_o <= 1'b0;
    wait_cyc(2);
  endtask

  task automatic start();
    sda_o <= 1'b1;
    wait_cyc(HALF);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_o <= 1'b0;
    wait_cyc(HALF);
    scl_o <= 1'b0;
    wait_cyc(2);
  endtask

  task automatic stop();
    sda_o <= 1'b0;
    wait_cyc(HALF);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_o <= 1'b1;
    wait_cyc(HALF);
  endtask

  // MSB first, then the acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // Last byte answered with a not-acknowledge to end the read
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask

  // Address then four registers; gives up after a refused address
  task automatic write_regs(input logic [6:0] a, input logic [31:0] d,
                            output logic [4:0] ack);
    ack = '0;
    start();
    send_byte({a, 1'b0}, ack[4]);
    for (int i = 3; i >= 0; i--) if (ack[4]) send_byte(d[i*8 +: 8], ack[i]);
    stop();
  endtask

  task automatic read_regs(output logic [31:0] d);
    logic a;
    start();
    send_byte({fld_pkg::DEV_ADDR, 1'b1}, a);
    for (int i = 3; i >= 0; i--) recv_byte(i == 0, d[i*8 +: 8]);
    stop();
  endtask
endmodule // fld_i2c_host

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fld_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  lvl;
    logic [7:0]  stb;
    logic [7:0]  sty;
    logic [12:0] vout;
    logic [2:0]  sh;
  } fld_row_t;

  localparam int TOUT[4] = '{20, 40, 60, 80};
  // Register bytes, output voltage and short flags per row
  localparam fld_row_t ROWS[7] = '{
    '{8'h48, 8'h00, 8'h00, 8'hA6, 13'h1130, 3'h0},
    '{8'h90, 8'h00, 8'h00, 8'h5F, 13'h112F, 3'h0},
    '{8'hD8, 8'hA0, 8'hFC, 8'h00, 13'h1450, 3'h0},
    '{8'hC0, 8'hFF, 8'h00, 8'h00, 13'h157B, 3'h0},
    '{8'h00, 8'h00, 8'h00, 8'hFE, 13'h1130, 3'h0},
    '{8'h50, 8'h00, 8'h00, 8'hFE, 13'h1130, 3'h2},
    '{8'hC3, 8'h00, 8'h00, 8'h00, 13'h1162, 3'h0}
  };

  logic        mclk_i, rst_i, pwr_down_n_i, strobe_trig_i;
  logic        uvlo_i, temp_fault_i, scl, host_sda, sda_line, sda_oe;
  logic        sda_dut;
  logic        ready_o, shutdown_o, strobe_active_o;
  logic [2:0]  led_short_i;
  logic [12:0] vout_mv_i;
  logic [1:0]  pump_gain_o;
  fld_led_t    led_o;
  int          err_count;
  int          checks;

  // Open-drain data line with pull-up; device drives its data value
  assign sda_line = host_sda & (sda_oe ? sda_dut : 1'b1);

  fld_ctrl #(.TOUT0_CYC(20), .TOUT1_CYC(40), .TOUT2_CYC(60), .TOUT3_CYC(80))
  i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .pwr_down_n_i(pwr_down_n_i),
    .strobe_trig_i(strobe_trig_i), .scl_i(scl), .sda_i(sda_line),
    .uvlo_i(uvlo_i), .temp_fault_i(temp_fault_i), .led_short_i(led_short_i),
    .vout_mv_i(vout_mv_i), .sda_o(sda_dut), .sda_oe_o(sda_oe),
    .ready_o(ready_o),
    .shutdown_o(shutdown_o), .strobe_active_o(strobe_active_o),
    .pump_gain_o(pump_gain_o), .led_o(led_o));

  fld_i2c_host i_host (.mclk_i(mclk_i), .sda_line_i(sda_line),
    .scl_o(scl), .sda_o(host_sda));

  // 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Ready threshold sits 100 mV under the active ceiling
  function automatic logic exp_rdy(input logic [7:0] c, l,
                                   input logic [12:0] v);
    int ceil;
    ceil = (c[7:6] == 2'h3) ? 4550 + 150 * l[7:5] : 4500;
    return int'(v) >= ceil - 100;
  endfunction

  // Torch follows steady register; flash lights only while strobing
  function automatic logic [6:0] exp_led(input logic [7:0] c, s,
                                         input logic [2:0] sh);
    if (sh != 3'h0 || c[7:6] == 2'h0 || c[7:6] == 2'h3) return 7'h00;
    return {s[5], s[6], s[7], s[4:1]};
  endfunction

  // Watchdog, about twice the expected run
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    fld_row_t    r;
    logic [4:0]  ack;
    logic [31:0] rd;
    logic [31:0] exp_rd;
    logic        rdy;
    int          n;
    rst_i = 1'b1;
    pwr_down_n_i = 1'b1;
    strobe_trig_i = 1'b0;
    uvlo_i = 1'b0;
    temp_fault_i = 1'b0;
    led_short_i = 3'h0;
    vout_mv_i = '0;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge mclk_i);
    check("shutdown_rst", shutdown_o, 1'b1);
    rst_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check("shutdown_run", shutdown_o, 1'b0);
    foreach (ROWS[k]) begin
      r = ROWS[k];
      i_host.write_regs(DEV_ADDR, {r.ctrl, r.lvl, r.stb, r.sty}, ack);
      check("ack", ack, 5'h1F);
      vout_mv_i <= r.vout;
      led_short_i <= r.sh;
      repeat (4) @(posedge mclk_i);
      rdy = exp_rdy(r.ctrl, r.lvl, r.vout);
      check("ready", ready_o, rdy);
      check("led", led_o, exp_led(r.ctrl, r.sty, r.sh));
      check("gain", pump_gain_o, r.ctrl[4:3]);
      i_host.read_regs(rd);
      exp_rd = {r.ctrl, r.lvl[7:5], rdy, 4'h0, r.stb, r.sty};
      check("readback", rd, exp_rd);
    end
    // Every timeout code, retriggered part way through
    for (int t = 0; t < 4; t++) begin
      i_host.write_regs(DEV_ADDR, {6'h30, t[1:0], 24'h00_C800}, ack);
      strobe_trig_i <= 1'b1;
      n = 0;
      while (strobe_active_o !== 1'b1 && n < 10) begin
        @(posedge mclk_i);
        n++;
      end
      n = 0;
      while (strobe_active_o === 1'b1 && n < 200) begin
        @(posedge mclk_i);
        n++;
        if (n == 3) check("led_strobe", led_o, 7'h32);
        strobe_trig_i <= (n != 5);
      end
      check("strobe_len", n, TOUT[t]);
      strobe_trig_i <= 1'b0;
    end
    i_host.write_regs(DEV_ADDR, 32'h4300_C800, ack);
    strobe_trig_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    check("strobe_torch", strobe_active_o, 1'b0);
    strobe_trig_i <= 1'b0;
    vout_mv_i <= '0;
    // Shutdown with retention set, then with it clear
    for (int k = 0; k < 2; k++) begin
      i_host.write_regs(DEV_ADDR, k ? 32'h4840_00E0 : 32'h6840_00E0, ack);
      repeat (4) @(posedge mclk_i);
      check("led_on", led_o, 7'h70);
      pwr_down_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      check("shutdown", shutdown_o, 1'b1);
      check("led_off", led_o, 7'h00);
      pwr_down_n_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      i_host.read_regs(rd);
      check("retained", rd, k ? 32'h0 : 32'h6840_00E0);
    end
    // Clock spikes on every bit must not disturb the transfer
    i_host.spike_en = 1'b1;
    i_host.write_regs(DEV_ADDR, 32'hD1A0_4C9E, ack);
    i_host.read_regs(rd);
    check("spike", rd, 32'hD1A0_4C9E);
    i_host.spike_en = 1'b0;
    // Reset in mid-run: outputs and registers back to reset values
    i_host.write_regs(DEV_ADDR, 32'h6840_00E0, ack);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check("rst_shdn", shutdown_o, 1'b1);
    check("rst_led", led_o, 7'h00);
    check("rst_gain", pump_gain_o, 2'h0);
    rst_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    check("rst_run", shutdown_o, 1'b0);
    i_host.read_regs(rd);
    check("rst_regs", rd, 32'h0);
    i_host.write_regs(7'h29, 32'h0, ack);
    check("wrong_addr", ack, 5'h00);
    uvlo_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    i_host.write_regs(DEV_ADDR, 32'h0, ack);
    check("uvlo_ack", ack, 5'h00);
    uvlo_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    i_host.write_regs(DEV_ADDR, 32'h0, ack);
    check("uvlo_clear", ack, 5'h1F);
    finish_test();
  end
endmodule // tb_top
